/* File: pkg/wsc_pkg.sv */
// Package with constants, carrier structs and state layout of the watchdog.
package wsc_pkg;

    // Clock rates and watchdog period; counts derive from the figures.
    localparam int unsigned CLK_HZ         = 40_000_000;
    localparam int unsigned RC_HZ          = 31_250;
    localparam int unsigned WDT_PERIOD_US  = 16_000;
    localparam int unsigned WDT_TICKS      = WDT_PERIOD_US * RC_HZ / 1_000_000;
    localparam int unsigned OST_TOSC       = 1024;
    localparam int unsigned OST_CYCLES     = OST_TOSC;

    // Register indices; the byte address is four times the index.
    localparam logic [11:0] IDX_OPTION     = 12'h081;
    localparam logic [11:0] IDX_STATUS     = 12'h083;
    localparam logic [11:0] IDX_CTRL       = 12'h084;
    localparam logic [11:0] IDX_IRQ_EN     = 12'h085;
    localparam logic [11:0] ADDR_OPTION    = 12'h204;
    localparam logic [11:0] ADDR_STATUS    = 12'h20C;
    localparam logic [11:0] ADDR_CTRL      = 12'h210;
    localparam logic [11:0] ADDR_IRQ_EN    = 12'h214;

    // Field positions and reset values.
    localparam int unsigned OPT_ASSIGN_BIT = 3;
    localparam int unsigned OPT_RATIO_LSB  = 0;
    localparam logic [7:0]  OPTION_RESET   = 8'hFF;
    localparam int unsigned STAT_TO_BIT    = 4;
    localparam int unsigned STAT_PD_BIT    = 3;
    localparam int unsigned STAT_SLEEP_BIT = 1;
    localparam int unsigned STAT_WDT_BIT   = 0;
    localparam int unsigned CTRL_GIE_BIT   = 0;
    localparam int unsigned CTRL_RC_BIT    = 1;
    localparam logic [15:0] CFG_WORD_ADDR  = 16'h2007;
    localparam int unsigned CFG_WATCHDOG_ENABLE_CFG_BIT  = 2;
    localparam logic [11:0] IRQ_VECTOR     = 12'h004;

    // Interrupt sources; only those in the wake mask have a clock in sleep.
    localparam int unsigned IRQ_W          = 11;
    localparam logic [10:0] WAKE_MASK      = 11'h3FB;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef enum logic [1:0] {
        ST_RUN    = 2'b00,
        ST_SLEEP  = 2'b01,
        ST_START  = 2'b10,
        ST_RESUME = 2'b11
    } wsc_mode_type;

    typedef struct packed {
        logic clear_watchdog_instr;
        logic sleep_instr;
        logic instr_retired;
    } wsc_core_req_type;

    typedef struct packed {
        logic core_run;
        logic wdt_reset;
        logic pin_reset;
        logic wake;
        logic prefetch_next;
        logic vector_req;
    } wsc_core_ctl_type;

    typedef struct packed {
        wsc_mode_type mode;
        logic         cfg_loaded;
        logic         wdt_en;
        logic [7:0]   option;
        logic         global_irq_enable;
        logic         rc_mode;
        logic [10:0]  irq_en;
        logic         timeout_flag_n;
        logic         powerdown_flag_n;
        logic [2:0]   rc_sync;
        logic [1:0]   pin_sync;
        logic [8:0]   wdt_base;
        logic [7:0]   div_cnt;
        logic         to_toggle;
        logic [2:0]   to_sync;
        logic [10:0]  ost_cnt;
        logic         wdt_reset;
        logic         wake;
        logic         prefetch;
        logic         timer_tick;
        logic         aw_full;
        logic [11:0]  aw_addr;
        logic         w_full;
        logic [31:0]  w_data;
        logic [3:0]   w_strb;
        logic         bvalid;
        logic [1:0]   bresp;
        logic         rvalid;
        logic [31:0]  rdata;
        logic [1:0]   rresp;
    } wsc_state_type;

    localparam wsc_state_type STATE_INIT = '{
        mode: ST_RUN, option: OPTION_RESET, timeout_flag_n: 1'b1,
        powerdown_flag_n: 1'b1, pin_sync: 2'b11, default: '0};

endpackage

/* File: core/wsc_core.sv */
// Watchdog, shared divider and sleep/wake control with an AXI4-Lite slave.
//
// Summary of operation
// [RULE_01] Watchdog counts RC ticks, forces RC on.
// [RULE_02] Unscaled time-out after 16 ms of RC.
// [RULE_03] Time-out while running resets the device.
// [RULE_04] Time-out while asleep wakes the device instead.
// [RULE_05] Every time-out clears the time-out flag.
// [RULE_06] Cleared enable configuration bit disables watchdog.
// [RULE_07] One divider shared by timer and watchdog.
// [RULE_08] Clear or sleep restarts watchdog and its divider.
// [RULE_09] Clearing keeps divider assignment and ratio intact.
// [RULE_10] Sleep entry: clear watchdog, update flags, stop oscillator.
// [RULE_11] Pins keep their drive state while asleep.
// [RULE_12] Reset pin resets; other wake sources resume.
// [RULE_13] Power-down flag set at power-up, cleared by sleep.
// [RULE_14] Only clocked-in-sleep peripherals may wake the device.
// [RULE_15] Wake needs individual enable, ignores global enable.
// [RULE_16] After wake run prefetched instruction, then vector.
// [RULE_17] Sleep instruction prefetches the next instruction.
// [RULE_18] Pending enabled interrupt turns sleep into no-operation.
// [RULE_19] Late interrupt: sleep completes, then immediate wake.
// [RULE_20] Wake waits 1024 oscillator periods unless RC mode.
// [RULE_21] Software clears watchdog before sleep, no-op after.
// [RULE_22] Global enable cleared on reset; enabled interrupts vector.
// [RULE_23] Time-out event synchronised before reset or wake.
module wsc_core
    import wsc_pkg::*;
(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             ce,
    input  wire logic [11:0]      s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [11:0]      s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    input  wire logic             internal_rc_osc,
    output logic                  internal_rc_osc_en,
    input  wire logic             master_reset_pin_n,
    input  wire logic [7:0]       config_word,
    input  wire wsc_core_req_type core_req,
    output wsc_core_ctl_type      core_ctl,
    input  wire logic [10:0]      irq_flags,
    input  wire logic             timer_src_tick,
    output logic                  timer_tick,
    output logic                  osc_driver_en,
    output logic                  io_hold,
    output logic                  timeout_flag_n,
    output logic                  powerdown_flag_n
);

    wsc_state_type st;
    wsc_state_type next_st;

    logic       rc_tick;
    logic       base_done;
    logic       to_fire;
    logic       divider_assign;
    logic [2:0] divider_ratio;
    logic [7:0] wdt_limit;
    logic [7:0] tmr_limit;
    logic       running;
    logic       pending;
    logic       wake_irq;
    logic       clr_go;
    logic       sleep_go;
    logic       soft_reset;
    logic       wr_go;
    logic       rd_go;

    // Decoded option fields and the two divider end counts.
    assign divider_assign = st.option[OPT_ASSIGN_BIT];
    assign divider_ratio  = st.option[OPT_RATIO_LSB +: 3];
    assign wdt_limit      = (8'h01 << divider_ratio) - 8'h01;
    assign tmr_limit      = (8'h02 << divider_ratio) - 8'h01;

    // Events seen by the state update; sleep no-ops on any enabled flag.
    assign running  = (st.mode == ST_RUN || st.mode == ST_RESUME);
    assign pending  = |(irq_flags & st.irq_en);
    assign wake_irq = |(irq_flags & st.irq_en & WAKE_MASK);  // [RULE_14]
    assign clr_go   = running && core_req.clear_watchdog_instr;
    assign sleep_go = running && core_req.sleep_instr && !pending;
    assign to_fire  = st.to_sync[1] ^ st.to_sync[2];          // [RULE_23]
    assign rc_tick  = st.rc_sync[1] & ~st.rc_sync[2] & st.wdt_en;
    assign base_done = rc_tick && (st.wdt_base == 9'(WDT_TICKS - 1));
    assign soft_reset = !st.pin_sync[1] || (to_fire && st.mode != ST_SLEEP);
    assign wr_go    = st.aw_full && st.w_full && !st.bvalid;
    assign rd_go    = s_axi_arvalid && s_axi_arready;

    // Readback of one register word; unmapped words answer with an error.
    function automatic logic [32:0] read_word(input wsc_state_type s,
                                              input logic [11:0] a);
        logic [32:0] r;
        r = 33'h0_0000_0000;
        case (a)
            ADDR_OPTION: r[7:0] = s.option;
            ADDR_STATUS: begin
                r[STAT_TO_BIT]    = s.timeout_flag_n;
                r[STAT_PD_BIT]    = s.powerdown_flag_n;
                r[STAT_SLEEP_BIT] = (s.mode == ST_SLEEP);
                r[STAT_WDT_BIT]   = s.wdt_en;
            end
            ADDR_CTRL: begin
                r[CTRL_GIE_BIT] = s.global_irq_enable;
                r[CTRL_RC_BIT]  = s.rc_mode;
            end
            ADDR_IRQ_EN: r[10:0] = s.irq_en;
            default: r[32] = 1'b1;
        endcase
        return r;
    endfunction

    // Whole next-state computation; ce low freezes everything.
    always_comb begin
        logic [32:0] rd;
        rd = read_word(st, s_axi_araddr);
        next_st = st;
        next_st.wdt_reset  = 1'b0;
        next_st.wake       = 1'b0;
        next_st.prefetch   = 1'b0;
        next_st.timer_tick = 1'b0;

        // Pin synchronisers; the first stage feeds only the second.
        next_st.rc_sync  = {st.rc_sync[1:0], internal_rc_osc};
        next_st.pin_sync = {st.pin_sync[0], master_reset_pin_n};
        next_st.to_sync  = {st.to_sync[1:0], st.to_toggle};  // [RULE_23]

        // The enable fuse is caught once, in the first cycle after reset.
        if (!st.cfg_loaded) begin
            next_st.cfg_loaded = 1'b1;
            next_st.wdt_en     = config_word[CFG_WATCHDOG_ENABLE_CFG_BIT];  // [RULE_06]
        end

        // Base watchdog period counted in RC edges.
        if (rc_tick) begin
            next_st.wdt_base = base_done ? 9'h000 : st.wdt_base + 9'h001;  // [RULE_02]
        end

        // Shared divider serves either the watchdog or the timer.
        if (divider_assign) begin
            next_st.timer_tick = timer_src_tick;  // [RULE_07]
            if (base_done) begin
                if (st.div_cnt >= wdt_limit) begin
                    next_st.div_cnt   = 8'h00;
                    next_st.to_toggle = ~st.to_toggle;
                end else begin
                    next_st.div_cnt = st.div_cnt + 8'h01;
                end
            end
        end else begin
            if (base_done) begin
                next_st.to_toggle = ~st.to_toggle;
            end
            if (timer_src_tick) begin
                if (st.div_cnt >= tmr_limit) begin
                    next_st.div_cnt    = 8'h00;
                    next_st.timer_tick = 1'b1;  // [RULE_07]
                end else begin
                    next_st.div_cnt = st.div_cnt + 8'h01;
                end
            end
        end

        // Clear and sleep restart the count; the option value is untouched.
        if (clr_go || sleep_go) begin
            next_st.wdt_base = 9'h000;  // [RULE_08]
            if (divider_assign) begin
                next_st.div_cnt = 8'h00;  // [RULE_09]
            end
        end

        // Sleep prefetches always, but only enters without a pending flag.
        next_st.prefetch = running && core_req.sleep_instr;  // [RULE_17]
        if (sleep_go) begin
            next_st.mode             = ST_SLEEP;  // [RULE_18]
            next_st.powerdown_flag_n = 1'b0;  // [RULE_13]
            next_st.timeout_flag_n   = 1'b1;  // [RULE_10]
        end

        // A time-out clears the flag; it wins over a sleep in the same cycle.
        if (to_fire) begin
            next_st.timeout_flag_n = 1'b0;  // [RULE_05]
            if (st.mode != ST_SLEEP) begin
                next_st.wdt_reset = 1'b1;  // [RULE_03]
            end
        end

        // Wake sequence; a flag that rose during sleep wakes at once.
        case (st.mode)
            ST_SLEEP: begin
                if (wake_irq || to_fire) begin  // [RULE_19]
                    next_st.wake    = 1'b1;  // [RULE_04]
                    next_st.ost_cnt = 11'h000;
                    next_st.mode    = st.rc_mode ? ST_RESUME : ST_START;
                end
            end
            ST_START: begin
                next_st.ost_cnt = st.ost_cnt + 11'h001;
                if (st.ost_cnt == 11'(OST_CYCLES - 1)) begin
                    next_st.mode = ST_RESUME;  // [RULE_20]
                end
            end
            ST_RESUME: begin
                if (core_req.instr_retired && !sleep_go) begin
                    next_st.mode = ST_RUN;  // [RULE_16]
                end
            end
            ST_RUN: begin
            end
            default: next_st.mode = ST_RUN;
        endcase

        // Register writes, taken once address and data are both held.
        if (s_axi_awvalid && s_axi_awready) begin
            next_st.aw_full = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_st.w_full = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
        end
        if (wr_go) begin
            next_st.aw_full = 1'b0;
            next_st.w_full  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = RESP_OKAY;
            case (st.aw_addr)
                ADDR_OPTION: begin
                    if (st.w_strb[0]) begin
                        next_st.option = st.w_data[7:0];  // [RULE_07]
                    end
                end
                ADDR_STATUS: begin
                end
                ADDR_CTRL: begin
                    if (st.w_strb[0]) begin
                        next_st.global_irq_enable     = st.w_data[CTRL_GIE_BIT];
                        next_st.rc_mode = st.w_data[CTRL_RC_BIT];
                    end
                end
                ADDR_IRQ_EN: begin
                    if (st.w_strb[0]) begin
                        next_st.irq_en[7:0] = st.w_data[7:0];
                    end
                    if (st.w_strb[1]) begin
                        next_st.irq_en[10:8] = st.w_data[10:8];
                    end
                end
                default: next_st.bresp = RESP_SLVERR;
            endcase
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end

        // Reads answer one cycle after the address is taken.
        if (rd_go) begin
            next_st.rvalid = 1'b1;
            next_st.rdata  = rd[31:0];
            next_st.rresp  = rd[32] ? RESP_SLVERR : RESP_OKAY;
        end else if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end

        // Device reset from the pin or a running time-out; flags survive.
        if (soft_reset) begin
            next_st.mode     = ST_RUN;  // [RULE_12]
            next_st.option   = OPTION_RESET;
            next_st.global_irq_enable      = 1'b0;  // [RULE_22]
            next_st.irq_en   = 11'h000;
            next_st.wdt_base = 9'h000;
            next_st.div_cnt  = 8'h00;
        end

        if (!ce) begin
            next_st = st;
        end
    end

    // The only state register of the block.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= STATE_INIT;
        end else begin
            st <= next_st;
        end
    end

    // Bus handshakes are stalled while the block is frozen.
    assign s_axi_awready = ce && !st.aw_full && !st.bvalid;
    assign s_axi_wready  = ce && !st.w_full && !st.bvalid;
    assign s_axi_arready = ce && !st.rvalid;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rdata   = st.rdata;
    assign s_axi_rresp   = st.rresp;

    // Core control; a vector needs the global enable and the ST_RUN mode.
    assign core_ctl.core_run      = running && st.pin_sync[1];
    assign core_ctl.wdt_reset     = st.wdt_reset;
    assign core_ctl.pin_reset     = !st.pin_sync[1];  // [RULE_12]
    assign core_ctl.wake          = st.wake;
    assign core_ctl.prefetch_next = st.prefetch;
    assign core_ctl.vector_req    = st.global_irq_enable && st.mode == ST_RUN
                                    && pending;  // [RULE_22]

    // Enabling the watchdog keeps the RC oscillator alive even in sleep.
    assign internal_rc_osc_en = st.wdt_en;  // [RULE_01]
    assign osc_driver_en      = (st.mode != ST_SLEEP);  // [RULE_10]
    assign io_hold            = (st.mode == ST_SLEEP);  // [RULE_11]
    assign timer_tick         = st.timer_tick;
    assign timeout_flag_n     = st.timeout_flag_n;
    assign powerdown_flag_n   = st.powerdown_flag_n;

    a_rc_forced_on: assert property ( // [RULE_01]
        @(posedge aclk) disable iff (!aresetn)
        st.wdt_en |-> internal_rc_osc_en)
        else $error("RC oscillator off while watchdog enabled");

    a_run_timeout_rst: assert property ( // [RULE_03]
        @(posedge aclk) disable iff (!aresetn)
        (ce && to_fire && st.mode != ST_SLEEP)
        |=> core_ctl.wdt_reset && st.mode == ST_RUN && !st.timeout_flag_n)
        else $error("Running time-out did not reset");

    a_sleep_timeout_wake: assert property ( // [RULE_04]
        @(posedge aclk) disable iff (!aresetn)
        (ce && to_fire && st.mode == ST_SLEEP && st.pin_sync[1])
        |=> core_ctl.wake && !core_ctl.wdt_reset && st.mode != ST_SLEEP)
        else $error("Sleeping time-out did not wake");

    a_disabled_quiet: assert property ( // [RULE_06]
        @(posedge aclk) disable iff (!aresetn)
        (st.cfg_loaded && !st.wdt_en) |-> !rc_tick && !base_done)
        else $error("Disabled watchdog is counting");

    a_clear_restarts: assert property ( // [RULE_08]
        @(posedge aclk) disable iff (!aresetn)
        (ce && clr_go && !soft_reset)
        |=> st.wdt_base == 9'h000 && $stable(st.option))
        else $error("Clear did not restart the watchdog");

    a_sleep_entry: assert property ( // [RULE_10]
        @(posedge aclk) disable iff (!aresetn)
        (ce && sleep_go && !soft_reset) |=> !st.powerdown_flag_n
        && st.mode == ST_SLEEP && io_hold && !osc_driver_en)
        else $error("Sleep entry effects missing");

    a_sleep_as_nop: assert property ( // [RULE_18]
        @(posedge aclk) disable iff (!aresetn)
        (ce && running && core_req.sleep_instr && pending && !soft_reset)
        |=> $stable(st.powerdown_flag_n) && st.mode != ST_SLEEP)
        else $error("Sleep with pending flag was not a no-op");

    a_start_delay: assert property ( // [RULE_20]
        @(posedge aclk) disable iff (!aresetn)
        (ce && st.mode == ST_START && st.ost_cnt == 11'(OST_CYCLES - 1)
         && st.pin_sync[1]) |=> st.mode == ST_RESUME)
        else $error("Start-up delay end missed");

    a_rc_wake_fast: assert property ( // [RULE_20]
        @(posedge aclk) disable iff (!aresetn)
        (ce && st.mode == ST_SLEEP && st.rc_mode && wake_irq
         && st.pin_sync[1]) |=> st.mode == ST_RESUME)
        else $error("RC mode wake was delayed");

    a_vector_gated: assert property ( // [RULE_16]
        @(posedge aclk) disable iff (!aresetn)
        core_ctl.vector_req |-> st.global_irq_enable && st.mode == ST_RUN)
        else $error("Vector raised before resume or without enable");

endmodule

/* File: dv/wsc_cpu_model.sv */
// Behavioural processor core that issues watchdog and sleep instructions.
module wsc_cpu_model
    import wsc_pkg::*;
(
    input  wire logic             aclk,
    input  wire wsc_core_ctl_type core_ctl,
    output wsc_core_req_type      core_req
);
    timeunit 1ns;
    timeprecision 1ps;

    logic armed;

    // Idle at time zero so no stray instruction reaches the block.
    initial begin
        core_req = '0;
        armed = 1'b0;
    end

    // One instruction is a single-cycle pulse launched after an edge.
    task automatic issue(input logic clr, input logic slp);
        @(posedge aclk);
        core_req.clear_watchdog_instr <= clr;
        core_req.sleep_instr <= slp;
        @(posedge aclk);
        core_req.clear_watchdog_instr <= 1'b0;
        core_req.sleep_instr <= 1'b0;
    endtask

    // Careful software clears the watchdog just before it sleeps.
    task automatic clear_then_sleep();
        issue(1'b1, 1'b0);
        issue(1'b0, 1'b1);
    endtask

    // After a wake the prefetched instruction retires once the core runs.
    always @(posedge aclk) begin
        core_req.instr_retired <= 1'b0;
        if (core_ctl.wake === 1'b1) begin
            armed <= 1'b1;
        end else if (armed && core_ctl.core_run === 1'b1) begin
            core_req.instr_retired <= 1'b1;
            armed <= 1'b0;
        end
    end
endmodule

/* File: dv/tb_watchdog_sleep_wake_control.sv */
// Self-checking bench for the watchdog and sleep/wake controller.
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin n_mismatch++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, s); end end
module tb_watchdog_sleep_wake_control
    import wsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic             aclk = 1'b0, aresetn = 1'b0, rc = 1'b0;
    logic [11:0]      awaddr = '0, araddr = '0;
    logic             awvalid = 0, wvalid = 0, bready = 0;
    logic             arvalid = 0, rready = 0;
    logic [31:0]      wdata = '0, rdata;
    logic [3:0]       wstrb = '0;
    logic [10:0]      flags = '0;
    logic             pin_n = 1'b1;
    logic [1:0]       bresp, rresp;
    logic             awready, wready, bvalid, arready, rvalid, rc_en;
    logic             osc_en, io_hold, to_n, pd_n;
    wsc_core_req_type req;
    wsc_core_ctl_type ctl;
    int               n_mismatch = 0, n_tests = 0;

    // Core clock, and an RC clock that only runs while the block asks.
    always #12.5 aclk = ~aclk;
    always #100 rc = rc_en ? ~rc : 1'b0;

    wsc_core uut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .internal_rc_osc(rc),
        .internal_rc_osc_en(rc_en), .master_reset_pin_n(pin_n),
        .config_word(8'h04), .core_req(req), .core_ctl(ctl),
        .irq_flags(flags), .timer_src_tick(1'b0), .timer_tick(),
        .osc_driver_en(osc_en), .io_hold(io_hold), .timeout_flag_n(to_n),
        .powerdown_flag_n(pd_n));

    wsc_cpu_model cpu (.aclk(aclk), .core_ctl(ctl), .core_req(req));

    // Write: address and data offered together, each dropped once taken.
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask

    // Read: the address stands until taken, rready is held until rvalid.
    task automatic rd(input logic [11:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // Reset values, access kinds and a clear that spares the settings.
    task automatic s_regs();
        logic [31:0] d;
        logic [1:0]  r;
        rd(ADDR_OPTION, d, r);
        `CHK("option", {24'h0, OPTION_RESET}, d)
        rd(ADDR_STATUS, d, r);
        `CHK("status", 32'h0000_0019, d)
        `CHK("rc on", 1'b1, rc_en)
        rd(12'h3FC, d, r);
        `CHK("unmapped", RESP_SLVERR, r)
        wr(ADDR_OPTION, 32'h0000_000A);
        cpu.issue(1'b1, 1'b0);
        rd(ADDR_OPTION, d, r);
        `CHK("option kept", 32'h0000_000A, d)
    endtask

    // A pending enabled flag turns sleep into a no-operation.
    task automatic s_nop_sleep();
        wr(ADDR_IRQ_EN, 32'h0000_0005);
        @(posedge aclk);
        flags <= 11'h001;
        cpu.issue(1'b0, 1'b1);
        repeat (3) @(negedge aclk);
        `CHK("nop pd", 1'b1, pd_n)
        `CHK("nop run", 1'b1, ctl.core_run)
        @(posedge aclk);
        flags <= '0;
    endtask

    // Sleep entry, a source with no clock, then an interrupt wake.
    task automatic s_irq_wake();
        logic [31:0] d;
        logic [1:0]  r;
        int          n;
        wr(ADDR_CTRL, 32'h0000_0001);
        cpu.clear_then_sleep();
        @(negedge aclk);
        `CHK("prefetch", 1'b1, ctl.prefetch_next)
        `CHK("sleep pd", 1'b0, pd_n)
        `CHK("sleep to", 1'b1, to_n)
        `CHK("osc off", 1'b0, osc_en)
        `CHK("io hold", 1'b1, io_hold)
        @(posedge aclk);
        flags <= 11'h004;
        repeat (20) @(negedge aclk);
        rd(ADDR_STATUS, d, r);
        `CHK("still asleep", 32'h0000_0013, d)
        @(posedge aclk);
        flags <= 11'h005;
        for (n = 0; n < 8 && ctl.wake !== 1'b1; n++) @(negedge aclk);
        `CHK("irq wake", 1'b1, ctl.wake)
        for (n = 0; n < 1100 && ctl.core_run !== 1'b1; n++) @(negedge aclk);
        `CHK("startup", 1'b1, n >= OST_CYCLES - 2 && n <= OST_CYCLES + 2)
        for (n = 0; n < 8 && ctl.vector_req !== 1'b1; n++) @(negedge aclk);
        `CHK("vector", 1'b1, ctl.vector_req)
        @(posedge aclk);
        flags <= '0;
    endtask

    // A clear restarts the count; the next time-out resets the device.
    task automatic s_wdt_run();
        logic [31:0] d;
        logic [1:0]  r;
        int          n;
        wr(ADDR_OPTION, 32'h0000_0000);
        cpu.issue(1'b1, 1'b0);
        repeat (3000) @(negedge aclk);
        cpu.issue(1'b1, 1'b0);
        for (n = 0; n < WDT_TICKS * 8 + 60 && ctl.wdt_reset !== 1'b1; n++)
            @(negedge aclk);
        `CHK("period", 1'b1, n > WDT_TICKS * 8 - 20 && n < WDT_TICKS * 8 + 40)
        repeat (2) @(negedge aclk);
        `CHK("to cleared", 1'b0, to_n)
        rd(ADDR_OPTION, d, r);
        `CHK("reset option", {24'h0, OPTION_RESET}, d)
    endtask

    // A time-out in sleep wakes at once in RC mode instead of resetting.
    task automatic s_wdt_sleep();
        int n;
        wr(ADDR_OPTION, 32'h0000_0000);
        wr(ADDR_CTRL, 32'h0000_0002);
        cpu.issue(1'b0, 1'b1);
        for (n = 0; n < WDT_TICKS * 8 + 60 && ctl.wake !== 1'b1; n++)
            @(negedge aclk);
        `CHK("wdt wake", 1'b1, ctl.wake)
        for (n = 0; n < 4 && ctl.core_run !== 1'b1; n++) @(negedge aclk);
        `CHK("no delay", 1'b1, ctl.core_run)
        `CHK("wake to", 1'b0, to_n)
        `CHK("wake pd", 1'b0, pd_n)
    endtask

    // The reset pin stops the core and drops the global enable but keeps RC mode.
    task automatic s_pin();
        logic [31:0] d;
        logic [1:0]  r;
        wr(ADDR_CTRL, 32'h0000_0003);
        @(posedge aclk);
        pin_n <= 1'b0;
        repeat (4) @(negedge aclk);
        `CHK("pin rst", 1'b1, ctl.pin_reset)
        `CHK("pin run", 1'b0, ctl.core_run)
        @(posedge aclk);
        pin_n <= 1'b1;
        repeat (4) @(posedge aclk);
        rd(ADDR_CTRL, d, r);
        `CHK("pin ctrl", 32'h0000_0002, d)
    endtask

    // Prints the verdict and ends the run.
    task automatic tally_and_finish();
        if (n_mismatch == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Main sequence after ten cycles of reset.
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        s_regs();
        s_nop_sleep();
        s_irq_wake();
        s_wdt_run();
        s_wdt_sleep();
        s_pin();
        tally_and_finish();
    end

    // About two and a half times the expected run length; a hang counts as a mismatch.
    initial begin
        #(30000 * 25);
        n_mismatch++;
        tally_and_finish();
    end
endmodule
